// ### rfm_pkg.sv
// Purpose: Shared constants and types for the receive link fault and range monitor.
// Assumes: One core clock at 100 MHz; serial inputs are sampled once per bit time.
// Notes:   Counts are derived from the figures held here.
package rfm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned RANGE_INTERVAL   = 4096;
    localparam int unsigned RANGE_PPM_LIMIT  = 1500;
    localparam int unsigned PPM_SCALE        = 1000000;
    localparam int unsigned CHAR_BITS        = 10;
    localparam int unsigned MAX_RUN_CHARS    = 6;
    localparam int unsigned MAX_RUN_BITS     = MAX_RUN_CHARS * CHAR_BITS;
    localparam int unsigned REF_WINDOW       = 16;
    localparam int unsigned REENABLE_TIME_MS = 2;

    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] AMP_DETECT_OFF = 2'h0;
    localparam logic [1:0] SPEED_LOW      = 2'h0;
    localparam logic [1:0] SPEED_MID      = 2'h1;
    localparam logic [1:0] SPEED_HIGH     = 2'h2;
    localparam logic       TRAIN_FULL     = 1'h0;
    localparam logic       TRAIN_HALF     = 1'h1;

    localparam logic       FAULT_N_RESET  = 1'h0;
    localparam logic [6:0] RUN_RESET      = 7'h00;
    localparam logic [4:0] REF_RESET      = 5'h00;

    typedef enum logic {
        RFM_MONITOR,
        RFM_FORCE
    } rfm_range_e;

endpackage

// ### rfm_rx_link_monitor.sv
// Purpose: Per-channel input selection, signal detect, range control and power enable.
// Assumes: All inputs are synchronous to core_clk; clock pins are sampled as levels.
// Notes:   Analog amplitude is supplied as a quantised level per line receiver.
`timescale 1ns/1ns

module rfm_rx_link_monitor
    import rfm_pkg::*;
#(
    parameter int unsigned CHANNELS       = 4,
    parameter int unsigned RANGE_INTERVAL = rfm_pkg::RANGE_INTERVAL
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [CHANNELS-1:0]      primary_serial_in,
    input  wire logic [CHANNELS-1:0]      secondary_serial_in,
    input  wire logic [CHANNELS-1:0][1:0] primary_amplitude_level,
    input  wire logic [CHANNELS-1:0][1:0] secondary_amplitude_level,
    input  wire logic [CHANNELS-1:0]      input_select,
    input  wire logic [1:0]               amplitude_threshold_sel,
    input  wire logic [CHANNELS-1:0]      local_control_override,
    input  wire logic [CHANNELS-1:0]      training_clock,
    input  wire logic [CHANNELS-1:0]      recovered_clock,
    input  wire logic [CHANNELS-1:0][1:0] speed_band_sel,
    input  wire logic [CHANNELS-1:0]      training_rate_sel,
    input  wire logic [CHANNELS-1:0]      receive_power_enable,
    output logic      [CHANNELS-1:0]      recovery_serial_data,
    output logic      [CHANNELS-1:0]      link_fault_n,
    output logic      [CHANNELS-1:0]      clock_data_recovery_follow_training,
    output logic      [CHANNELS-1:0]      recovery_enabled
);
    import rfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Expected training edges per interval and the ppm tolerance, rounded down.
    localparam int unsigned WIN_W    = $clog2(RANGE_INTERVAL + 1);
    localparam int unsigned EXP_FULL = RANGE_INTERVAL;
    localparam int unsigned EXP_HALF = RANGE_INTERVAL / 2;
    localparam int unsigned TOL_FULL = (EXP_FULL * RANGE_PPM_LIMIT) / PPM_SCALE;
    localparam int unsigned TOL_HALF = (EXP_HALF * RANGE_PPM_LIMIT) / PPM_SCALE;
    localparam logic [WIN_W-1:0] WIN_LAST   = WIN_W'(RANGE_INTERVAL - 1);
    localparam logic [WIN_W-1:0] EXP_FULL_W = WIN_W'(EXP_FULL);
    localparam logic [WIN_W-1:0] EXP_HALF_W = WIN_W'(EXP_HALF);
    localparam logic [WIN_W-1:0] TOL_FULL_W = WIN_W'(TOL_FULL);
    localparam logic [WIN_W-1:0] TOL_HALF_W = WIN_W'(TOL_HALF);
    localparam logic [6:0]       RUN_LIMIT  = 7'(MAX_RUN_BITS);
    localparam logic [4:0]       REF_LIMIT  = 5'(REF_WINDOW);

    ////////////////////////////////////////////////////////////////////////////////
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        rfm_range_e       state_reg,     state_next;
        logic             range_ok_reg,  range_ok_next;
        logic [WIN_W-1:0] win_cnt_reg,   win_cnt_next;
        logic [WIN_W-1:0] trn_cnt_reg,   trn_cnt_next;
        logic [6:0]       run_cnt_reg,   run_cnt_next;
        logic [4:0]       ref_cnt_reg,   ref_cnt_next;
        logic             data_prev_reg, data_prev_next;
        logic             rec_prev_reg,  rec_prev_next;
        logic             trn_prev_reg,  trn_prev_next;
        logic             fault_n_reg,   fault_n_next;
        logic             sel_data_reg,  sel_data_next;
        logic             power_reg,     power_next;
        logic             sel_data;
        logic [1:0]       sel_level;
        logic             rec_edge;
        logic             trn_edge;
        logic             amp_ok;
        logic             trans_ok;
        logic             ref_ok;
        logic             reserved;
        logic [WIN_W-1:0] expected;
        logic [WIN_W-1:0] tolerance;
        logic [WIN_W-1:0] deviation;
        logic [WIN_W-1:0] win_trn;
        logic             valid;

        always_comb begin
            sel_data  = input_select[ch] ? primary_serial_in[ch]
                                         : secondary_serial_in[ch];
            sel_level = input_select[ch] ? primary_amplitude_level[ch]
                                         : secondary_amplitude_level[ch];
            rec_edge  = recovered_clock[ch] & ~rec_prev_reg;
            trn_edge  = training_clock[ch] & ~trn_prev_reg;
            amp_ok    = (amplitude_threshold_sel == AMP_DETECT_OFF) ||
                        (sel_level >= amplitude_threshold_sel);
            trans_ok  = run_cnt_reg <= RUN_LIMIT;
            ref_ok    = ref_cnt_reg < REF_LIMIT;
            // The low band cannot be trained at half rate, nor can an unused band code.
            reserved  = ((speed_band_sel[ch] == SPEED_LOW) &&
                         (training_rate_sel[ch] == TRAIN_HALF)) ||
                        (speed_band_sel[ch] > SPEED_HIGH);
            expected  = (training_rate_sel[ch] == TRAIN_HALF) ? EXP_HALF_W
                                                              : EXP_FULL_W;
            tolerance = (training_rate_sel[ch] == TRAIN_HALF) ? TOL_HALF_W : TOL_FULL_W;
            // The edge that closes a window counts in it, so every window is equally long.
            win_trn   = trn_edge ? trn_cnt_reg + WIN_W'(1) : trn_cnt_reg;
            deviation = (win_trn > expected) ? win_trn - expected
                                             : expected - win_trn;
            valid     = power_reg && amp_ok && trans_ok && ref_ok &&
                        range_ok_reg && !local_control_override[ch] &&
                        (state_reg == RFM_MONITOR);

            data_prev_next = sel_data;
            rec_prev_next  = recovered_clock[ch];
            trn_prev_next  = training_clock[ch];
            sel_data_next  = sel_data;
            power_next     = receive_power_enable[ch];
            state_next     = state_reg;
            range_ok_next  = range_ok_reg;
            win_cnt_next   = win_cnt_reg;
            trn_cnt_next   = win_trn;
            fault_n_next   = fault_n_reg;

            // Each core cycle is one bit time; the run counter saturates past the limit.
            if (sel_data != data_prev_reg) begin
                run_cnt_next = RUN_RESET;
            end else if (run_cnt_reg <= RUN_LIMIT) begin
                run_cnt_next = run_cnt_reg + 7'h01;
            end else begin
                run_cnt_next = run_cnt_reg;
            end

            if (trn_edge) begin
                ref_cnt_next = REF_RESET;
            end else if (rec_edge && ref_cnt_reg < REF_LIMIT) begin
                ref_cnt_next = ref_cnt_reg + 5'h01;
            end else begin
                ref_cnt_next = ref_cnt_reg;
            end

            if (rec_edge) begin
                if (win_cnt_reg == WIN_LAST) begin
                    win_cnt_next = '0;
                    trn_cnt_next = '0;
                    unique case (state_reg)
                        RFM_MONITOR: begin
                            if (reserved || deviation > tolerance) begin
                                state_next    = RFM_FORCE;
                                range_ok_next = 1'b0;
                            end else begin
                                range_ok_next = 1'b1;
                            end
                        end
                        RFM_FORCE: begin
                            // Release and judge lock over the next whole interval.
                            state_next    = RFM_MONITOR;
                            range_ok_next = 1'b0;
                        end
                    endcase
                end else begin
                    win_cnt_next = win_cnt_reg + WIN_W'(1);
                end
                fault_n_next = valid;
            end

            if (state_next == RFM_FORCE) begin
                fault_n_next = 1'b0;
            end

            // A powered-down channel starts afresh, so re-enable always relocks.
            if (!receive_power_enable[ch] || !power_reg) begin
                state_next    = RFM_MONITOR;
                range_ok_next = 1'b0;
                win_cnt_next  = '0;
                trn_cnt_next  = '0;
                fault_n_next  = 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                state_reg     <= RFM_MONITOR;
                range_ok_reg  <= 1'b0;
                win_cnt_reg   <= '0;
                trn_cnt_reg   <= '0;
                run_cnt_reg   <= RUN_RESET;
                ref_cnt_reg   <= REF_RESET;
                data_prev_reg <= 1'b0;
                rec_prev_reg  <= 1'b0;
                trn_prev_reg  <= 1'b0;
                fault_n_reg   <= FAULT_N_RESET;
                sel_data_reg  <= 1'b0;
                power_reg     <= 1'b0;
            end else begin
                state_reg     <= state_next;
                range_ok_reg  <= range_ok_next;
                win_cnt_reg   <= win_cnt_next;
                trn_cnt_reg   <= trn_cnt_next;
                run_cnt_reg   <= run_cnt_next;
                ref_cnt_reg   <= ref_cnt_next;
                data_prev_reg <= data_prev_next;
                rec_prev_reg  <= rec_prev_next;
                trn_prev_reg  <= trn_prev_next;
                fault_n_reg   <= fault_n_next;
                sel_data_reg  <= sel_data_next;
                power_reg     <= power_next;
            end
        end

        assign recovery_serial_data[ch]                = sel_data_reg;
        assign link_fault_n[ch]                        = fault_n_reg;
        assign clock_data_recovery_follow_training[ch] = (state_reg == RFM_FORCE);
        assign recovery_enabled[ch]                    = power_reg;
    end

endmodule // rfm_rx_link_monitor

// ### rfm_rx_link_monitor_asserts.sv
// Purpose: Port assertions for the receive link monitor.
// Assumes: Synchronous active high reset on core_clk.
// Notes:   A fault release is tied to causes sampled one cycle before it.
`timescale 1ns/1ns
module rfm_rx_link_monitor_asserts #(parameter int unsigned CHANNELS = 4) (
    input wire logic                     core_clk,
    input wire logic                     rst,
    input wire logic [CHANNELS-1:0]      primary_serial_in,
    input wire logic [CHANNELS-1:0]      secondary_serial_in,
    input wire logic [CHANNELS-1:0][1:0] primary_amplitude_level,
    input wire logic [CHANNELS-1:0][1:0] secondary_amplitude_level,
    input wire logic [CHANNELS-1:0]      input_select,
    input wire logic [1:0]               amplitude_threshold_sel,
    input wire logic [CHANNELS-1:0]      local_control_override,
    input wire logic [CHANNELS-1:0]      recovered_clock,
    input wire logic [CHANNELS-1:0]      receive_power_enable,
    input wire logic [CHANNELS-1:0]      recovery_serial_data,
    input wire logic [CHANNELS-1:0]      link_fault_n,
    input wire logic [CHANNELS-1:0]      clock_data_recovery_follow_training,
    input wire logic [CHANNELS-1:0]      recovery_enabled
);
    logic [CHANNELS-1:0] amp_ok;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            amp_ok[i] = (amplitude_threshold_sel == 2'h0) ||
                ((input_select[i] ? primary_amplitude_level[i] : secondary_amplitude_level[i])
                >= amplitude_threshold_sel);
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    path_select_a: assert property (
        ((recovery_serial_data ^ (($past(input_select) & $past(primary_serial_in)) |
        (~$past(input_select) & $past(secondary_serial_in)))) &
        recovery_enabled & $past(recovery_enabled)) == '0)
        else $error("selected serial line not passed to recovery");
    power_delay_a: assert property (
        !$past(rst) |-> recovery_enabled == $past(receive_power_enable))
        else $error("receive enable does not follow its setting");
    disabled_fault_a: assert property (
        (link_fault_n & ~recovery_enabled & ~$past(recovery_enabled)) == '0)
        else $error("disabled channel shows no fault");
    force_fault_a: assert property (
        (link_fault_n & clock_data_recovery_follow_training) == '0)
        else $error("fault released while oscillator is forced");
    rise_edge_a: assert property (
        (link_fault_n & ~$past(link_fault_n) &
        ~($past(recovered_clock) & ~$past(recovered_clock, 2))) == '0)
        else $error("fault released away from a recovered edge");
    rise_amp_a: assert property (
        (link_fault_n & ~$past(link_fault_n) & ~$past(amp_ok)) == '0)
        else $error("fault released with amplitude below threshold");
    rise_override_a: assert property (
        (link_fault_n & ~$past(link_fault_n) & $past(local_control_override)) == '0)
        else $error("fault released under local override");
    relock_hold_a: assert property (
        $fell(clock_data_recovery_follow_training[CHANNELS-1]) |->
        !link_fault_n[CHANNELS-1] [*8])
        else $error("fault released right after forcing ended");
endmodule // rfm_rx_link_monitor_asserts
////////////////////////////////////////////////////////////////////////////////
bind rfm_rx_link_monitor rfm_rx_link_monitor_asserts #(.CHANNELS(CHANNELS)) chk_u (.core_clk, .rst,
    .primary_serial_in, .secondary_serial_in, .primary_amplitude_level, .secondary_amplitude_level,
    .input_select, .amplitude_threshold_sel, .local_control_override, .recovered_clock,
    .receive_power_enable, .recovery_serial_data, .link_fault_n,
    .clock_data_recovery_follow_training, .recovery_enabled);

// ### rfm_far_model.sv
// Purpose: Far side model: remote serial stream and training clock source.
// Assumes: One recovered clock edge every four core cycles.
// Notes:   Skew swaps the training rate so range control sees half the edges it expects at full rate and twice as many at half rate.
`timescale 1ns/1ns
module rfm_far_model #(parameter int unsigned CHANNELS = 2) (
    input  wire logic                core_clk,
    input  wire logic [CHANNELS-1:0] stuck,
    input  wire logic [CHANNELS-1:0] half,
    input  wire logic [CHANNELS-1:0] skew,
    input  wire logic [CHANNELS-1:0] still,
    output logic      [CHANNELS-1:0] serial_out,
    output logic      [CHANNELS-1:0] rec_clk,
    output logic      [CHANNELS-1:0] trg_clk
);
    logic [2:0] phase_reg = 3'h0;
    always @(negedge core_clk) phase_reg <= phase_reg + 3'h1;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            serial_out[i] = stuck[i] ? 1'b0 : phase_reg[0];
            rec_clk[i]    = phase_reg[1];
            // A stopped training clock stands low, as an absent reference would.
            trg_clk[i]    = still[i] ? 1'b0 :
                            (half[i] ^ skew[i]) ? phase_reg[2] : phase_reg[1];
        end
    end
endmodule // rfm_far_model

// ### rfm_rx_link_monitor_test.sv
// Purpose: Self-checking bench for the receive link monitor.
// Assumes: Two channels and a 64 edge range window keep the run short.
// Notes:   Fault waits are bounded, so a lock that never comes shows as a mismatch.
`timescale 1ns/1ns
module rfm_rx_link_monitor_test;
    import rfm_pkg::*;
    localparam int unsigned CH = 2;
    localparam int unsigned RI = 64;
    logic               core_clk = 1'b0, rst = 1'b1;
    logic [CH-1:0]      pri, sec, trg, rec, rsd, lf_n, follow, ren;
    logic [CH-1:0]      sel = '1, ovr = '0, stuck = '0, skew = '0, trate = '0, pwr = '0;
    logic [CH-1:0]      still = '0;
    logic [CH-1:0][1:0] pamp = 4'hA, samp = 4'h0, spd = 4'h5;
    logic [1:0]         thr = 2'h1;
    int                 errors = 0, compares = 0, cyc = 0, n;
    always #5 core_clk = ~core_clk;
    assign sec = ~pri;
    rfm_far_model #(.CHANNELS(CH)) far_u (.core_clk, .stuck, .half(trate), .skew, .still,
        .serial_out(pri), .rec_clk(rec), .trg_clk(trg));
    rfm_rx_link_monitor #(.CHANNELS(CH), .RANGE_INTERVAL(RI)) dut_u (.core_clk, .rst,
        .primary_serial_in(pri), .secondary_serial_in(sec), .primary_amplitude_level(pamp),
        .secondary_amplitude_level(samp), .input_select(sel), .amplitude_threshold_sel(thr),
        .local_control_override(ovr), .training_clock(trg), .recovered_clock(rec),
        .speed_band_sel(spd), .training_rate_sel(trate), .receive_power_enable(pwr),
        .recovery_serial_data(rsd), .link_fault_n(lf_n),
        .clock_data_recovery_follow_training(follow), .recovery_enabled(ren));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle(input string nm, input logic [CH-1:0] exp);
        for (int k = 0; k < 1200 && lf_n !== exp; k++) @(negedge core_clk);
        check(nm, 8'(lf_n), 8'(exp));
    endtask
    task automatic span(input logic lvl);
        for (n = 0; n < 600 && follow[1] === lvl; n++) @(negedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        check("after reset", 8'({ren, lf_n}), 8'h00);
        pwr = 2'b11;
        settle("lock", 2'b11);
        for (int t = 0; t < 4; t++) begin
            thr = 2'(t + 3);
            settle("threshold", (t == 0) ? 2'b00 : 2'b11);
        end
        $display("test lock and threshold done");
        sel = 2'b10;
        settle("select", 2'b10);
        samp = 4'h3;
        settle("reselect", 2'b11);
        ovr = 2'b10;
        settle("override", 2'b01);
        ovr = 2'b00;
        stuck = 2'b01;
        settle("stuck data", 2'b10);
        check("recovered data", 8'(rsd[0]), 8'h01);
        stuck = 2'b00;
        $display("test detect conditions done");
        skew = 2'b10;
        settle("range", 2'b01);
        check("follow", 8'(follow), 8'h02);
        span(1'b1);
        span(1'b0);
        check("monitor span", 8'((n + 2) / 4), 8'(RI));
        span(1'b1);
        check("force span", 8'((n + 2) / 4), 8'(RI));
        skew = 2'b00;
        // A window has just begun, so only the missing reference can fault channel 0 here.
        still = 2'b01;
        repeat (80) @(negedge core_clk);
        check("no training clock", 8'({follow, lf_n}), 8'h00);
        still = 2'b00;
        settle("relock", 2'b11);
        trate = 2'b10;
        spd = 4'h9;
        settle("half rate", 2'b11);
        spd = 4'h1;
        settle("reserved", 2'b01);
        $display("test range done");
        pwr = 2'b10;
        repeat (300) @(negedge core_clk);
        check("power off", 8'({ren, lf_n}), 8'h08);
        pwr = 2'b11;
        spd = 4'h9;
        repeat (200) @(negedge core_clk);
        settle("re-enable", 2'b11);
        $display("test power done");
        tally_and_finish();
    end
endmodule // rfm_rx_link_monitor_test
